// file: ctl_pkg.sv
// Package: constants and types of the charge trip latch block
package ctl_pkg;

    // ********************************************************
    // Register map (APB byte addresses)
    // ********************************************************
    localparam logic [7:0] CTL_A_CONN = 8'h00;
    localparam logic [7:0] CTL_A_CFG = 8'h04;
    localparam logic [7:0] CTL_A_REQ = 8'h08;
    localparam logic [7:0] CTL_A_RESP = 8'h0C;
    localparam logic [7:0] CTL_A_OUT = 8'h10;
    localparam logic [7:0] CTL_A_IST = 8'h14;
    localparam logic [7:0] CTL_A_IMSK = 8'h18;

    // ********************************************************
    // Field positions and limits
    // ********************************************************
    localparam int CTL_CFG_CRC_BIT = 16;
    localparam logic [5:0] CTL_ILIM_MIN = 6'h06;
    localparam logic [5:0] CTL_ILIM_MAX = 6'h20;
    localparam int CTL_NEVT = 4;
    localparam int CTL_EV_TRIP = 0;
    localparam int CTL_EV_DROP = 1;
    localparam int CTL_EV_FERR = 2;
    localparam int CTL_EV_CABLE = 3;

    // ********************************************************
    // Timing
    // ********************************************************
    localparam int CTL_CLK_HZ = 100_000_000;
    localparam int CTL_TICK_MS = 1;
    localparam int CTL_TICK_CYC = CTL_TICK_MS * (CTL_CLK_HZ / 1000);
    localparam int CTL_DEF_TMO_MS = 2000;

    // ********************************************************
    // Vehicle state codes (pilot pins and response field)
    // ********************************************************
    localparam logic [2:0] CTL_VS_INV = 3'h0;
    localparam logic [2:0] CTL_VS_A = 3'h1;
    localparam logic [2:0] CTL_VS_B = 3'h2;
    localparam logic [2:0] CTL_VS_C = 3'h3;
    localparam logic [2:0] CTL_VS_D = 3'h4;
    localparam logic [2:0] CTL_VS_E = 3'h5;
    localparam logic [2:0] CTL_VS_F = 3'h6;

    // Proximity codes and the cable capacity each one means
    localparam logic [2:0] CTL_PX_NONE = 3'h0;
    localparam logic [2:0] CTL_PX_BAD = 3'h7;
    localparam logic [6:0] CTL_CAP_13 = 7'h0D;
    localparam logic [6:0] CTL_CAP_20 = 7'h14;
    localparam logic [6:0] CTL_CAP_32 = 7'h20;
    localparam logic [6:0] CTL_CAP_63 = 7'h3F;

    // ********************************************************
    // Process data request word
    // ********************************************************
    typedef struct packed {
        logic [7:0] crc;
        logic [7:0] dout;
        logic [1:0] rsv1;
        logic [5:0] ilim;
        logic [4:0] rsv0;
        logic clr;
        logic brk;
        logic pwm;
    } ctl_req_t;

    // Pilot outputs toward the vehicle interface
    typedef struct packed {
        logic pwm;
        logic brk;
        logic [5:0] ilim;
        logic [7:0] dout;
    } ctl_out_t;

endpackage : ctl_pkg

// file: ctl_trip.sv
// Module: trip latch and process data slave of the charge controller
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module ctl_trip import ctl_pkg::*; #(
    parameter int TICK_CYCLES = CTL_TICK_CYC,
    parameter int DEF_TMO_MS = CTL_DEF_TMO_MS
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Vehicle interface pins
    input wire logic [2:0] pilot_code,
    input wire logic [2:0] prox_code,
    // Outputs
    output logic shutdown_output_n,
    output ctl_out_t pilot_out,
    output logic irq
);

    // ********************************************************
    // State
    // ********************************************************
    typedef struct packed {
        logic [2:0] pil_s1;
        logic [2:0] pil_s2;
        logic [2:0] prx_s1;
        logic [2:0] prx_s2;
        logic [2:0] prx_prev;
        logic conn;
        logic crc_en;
        logic [15:0] tmo_ms;
        logic [16:0] ms_cnt;
        logic [15:0] tmo_cnt;
        logic sd_n;
        logic clr_pend;
        ctl_out_t po;
        logic [CTL_NEVT-1:0] ist;
        logic [CTL_NEVT-1:0] imsk;
        logic [31:0] rdata;
    } ctl_state_t;

    ctl_state_t r;
    ctl_state_t next_r;

    // ********************************************************
    // Decode of the synchronised pins
    // ********************************************************
    logic fault;
    logic [2:0] vstate;
    logic [6:0] cap;
    logic pil_ok;

    always_comb begin
        pil_ok = (r.pil_s2 >= CTL_VS_A) && (r.pil_s2 <= CTL_VS_D);
        fault = (r.pil_s2 == CTL_VS_E) || (r.pil_s2 == CTL_VS_F) ||
                (r.prx_s2 == CTL_PX_BAD);
        unique case (r.prx_s2)
            3'h1: cap = CTL_CAP_13;
            3'h2: cap = CTL_CAP_20;
            3'h3: cap = CTL_CAP_32;
            3'h4: cap = CTL_CAP_63;
            default: cap = 7'h00;
        endcase
        if (r.prx_s2 == CTL_PX_NONE) begin
            vstate = CTL_VS_A;
        end else if (!pil_ok || r.pil_s2 == CTL_VS_A) begin
            vstate = CTL_VS_INV;
        end else begin
            vstate = r.pil_s2;
        end
    end

    // ********************************************************
    // Bus decode
    // ********************************************************
    ctl_req_t req;
    logic acc;
    logic wr;
    logic mapped;
    logic tick;
    logic req_wr;
    logic frame_bad;
    logic cfg_wr;
    logic [7:0] crc_calc;
    logic [CTL_NEVT-1:0] evt;

    always_comb begin
        req = ctl_req_t'(pwdata);
        acc = psel && penable;
        wr = acc && pwrite;
        mapped = (paddr <= CTL_A_IMSK) && (paddr[1:0] == 2'b00);
        tick = (r.ms_cnt == 17'(TICK_CYCLES - 1));
        req_wr = wr && paddr == CTL_A_REQ && r.conn;
        cfg_wr = wr && paddr == CTL_A_CFG && r.conn;
        crc_calc = pwdata[7:0] ^ pwdata[15:8] ^ pwdata[23:16];
        // Zero current is legal: it is the idle request
        frame_bad = (r.crc_en && req.crc != crc_calc) ||
                    (req.ilim != 6'h00 &&
                     (req.ilim < CTL_ILIM_MIN || req.ilim > CTL_ILIM_MAX));
    end

    assign pready = 1'b1;
    assign pslverr = acc && !mapped;
    assign prdata = r.rdata;
    assign shutdown_output_n = r.sd_n;
    assign pilot_out = r.po;
    assign irq = |(r.ist & r.imsk);

    // ********************************************************
    // Next state
    // ********************************************************
    always_comb begin
        next_r = r;
        evt = '0;
        // Two flops on every pin before any logic reads it
        next_r.pil_s1 = pilot_code;
        next_r.pil_s2 = r.pil_s1;
        next_r.prx_s1 = prox_code;
        next_r.prx_s2 = r.prx_s1;
        next_r.prx_prev = r.prx_s2;
        evt[CTL_EV_CABLE] = (r.prx_s2 != r.prx_prev);
        next_r.ms_cnt = tick ? 17'h00000 : r.ms_cnt + 17'h00001;

        // Link supervision
        if (wr && paddr == CTL_A_CONN) begin
            if (pwdata[0] && !r.conn) begin
                next_r.conn = 1'b1;
                next_r.tmo_cnt = r.tmo_ms;
            end else if (!pwdata[0]) begin
                next_r.conn = 1'b0;
            end
        end
        if (r.conn && tick) begin
            if (r.tmo_cnt == 16'h0000) begin
                next_r.conn = 1'b0;
            end else begin
                next_r.tmo_cnt = r.tmo_cnt - 16'h0001;
            end
        end
        if (cfg_wr) begin
            if (pwdata[15:0] == 16'h0000) begin
                next_r.conn = 1'b0;
                evt[CTL_EV_FERR] = 1'b1;
            end else begin
                next_r.tmo_ms = pwdata[15:0];
                next_r.crc_en = pwdata[CTL_CFG_CRC_BIT];
                next_r.tmo_cnt = pwdata[15:0];
            end
        end
        if (req_wr) begin
            if (frame_bad) begin
                next_r.conn = 1'b0;
                evt[CTL_EV_FERR] = 1'b1;
            end else begin
                next_r.po.pwm = req.pwm;
                next_r.po.brk = req.brk;
                next_r.po.ilim = req.ilim;
                next_r.po.dout = req.dout;
                next_r.tmo_cnt = r.tmo_ms;
                if (req.clr) begin
                    next_r.clr_pend = 1'b1;
                end
            end
        end
        evt[CTL_EV_DROP] = r.conn && !next_r.conn;

        // Trip latch; a fault in the clear cycle keeps it set
        if (!next_r.conn) begin
            next_r.sd_n = 1'b0;
            next_r.clr_pend = 1'b0;
            next_r.po = '0;
            next_r.crc_en = r.conn ? 1'b0 : r.crc_en;
            next_r.tmo_ms = r.conn ? 16'(DEF_TMO_MS) : r.tmo_ms;
        end else if (fault) begin
            next_r.sd_n = 1'b0;
        end else if (next_r.clr_pend) begin
            next_r.sd_n = 1'b1;
            next_r.clr_pend = 1'b0;
        end
        // Isolating the outlet has no path into the latch
        evt[CTL_EV_TRIP] = r.sd_n && !next_r.sd_n;

        // Register writes and sticky status, set beats clear
        if (wr && paddr == CTL_A_IMSK) begin
            next_r.imsk = pwdata[CTL_NEVT-1:0];
        end
        for (int i = 0; i < CTL_NEVT; i++) begin
            if (wr && paddr == CTL_A_IST && pwdata[i]) begin
                next_r.ist[i] = 1'b0;
            end
            if (evt[i]) begin
                next_r.ist[i] = 1'b1;
            end
        end

        // Read data captured in the setup phase
        if (psel && !penable && !pwrite) begin
            unique case (paddr)
                CTL_A_CONN: next_r.rdata = {31'h0, r.conn};
                CTL_A_CFG: next_r.rdata = {15'h0, r.crc_en, r.tmo_ms};
                CTL_A_RESP: next_r.rdata = {17'h0, r.clr_pend, r.conn,
                    !r.sd_n, 1'b0, cap, 1'b0, vstate};
                CTL_A_OUT: next_r.rdata = {16'h0, r.po};
                CTL_A_IST: next_r.rdata = {28'h0, r.ist};
                CTL_A_IMSK: next_r.rdata = {28'h0, r.imsk};
                default: next_r.rdata = 32'h00000000;
            endcase
        end
    end

    // ********************************************************
    // Registers
    // ********************************************************
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            r <= '0;
            r.tmo_ms <= 16'(DEF_TMO_MS);
        end else begin
            r <= next_r;
        end
    end

    // ********************************************************
    // Assertions
    // ********************************************************
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);

    // Pins pass two flops, so a fault reaches the latch on the third edge
    trip_on_fault_a: assert property (fault |=> !shutdown_output_n)
        else $error("fault did not assert shutdown");

    release_needs_clear_a: assert property (
        $rose(shutdown_output_n) |-> $past(r.clr_pend) ||
        ($past(req_wr) && $past(req.clr)))
        else $error("shutdown released without clear");

    release_no_fault_a: assert property (
        $rose(shutdown_output_n) |-> !$past(fault))
        else $error("shutdown released during fault");

    // No input stands for outlet isolation, so only a clear can free it
    trip_hold_a: assert property (
        !shutdown_output_n && !req_wr && !r.clr_pend
        |=> !shutdown_output_n)
        else $error("shutdown released on its own");

    default_state_a: assert property (
        !r.conn |-> !shutdown_output_n && pilot_out == '0)
        else $error("default state not held");

    drop_restore_a: assert property (
        $fell(r.conn) |-> !r.crc_en && r.tmo_ms == 16'(DEF_TMO_MS)
            && r.ist[CTL_EV_DROP])
        else $error("drop did not restore defaults");

    timeout_drop_a: assert property (
        r.conn && tick && r.tmo_cnt == 16'h0000 |=> !r.conn)
        else $error("timeout did not drop link");

    frame_drop_a: assert property (
        req_wr && frame_bad |=> !r.conn ##0 r.ist[CTL_EV_FERR])
        else $error("bad frame did not drop link");

    crc_check_a: assert property (
        req_wr && r.crc_en && req.crc != crc_calc |=> !r.conn)
        else $error("checksum error not treated as frame error");

    cfg_apply_a: assert property (
        cfg_wr && pwdata[15:0] != 16'h0000
        |=> r.crc_en == $past(pwdata[CTL_CFG_CRC_BIT])
            && r.tmo_ms == $past(pwdata[15:0]))
        else $error("configuration not applied");

    req_apply_a: assert property (
        req_wr && !frame_bad |=> pilot_out.ilim == $past(req.ilim)
            && pilot_out.brk == $past(req.brk)
            && pilot_out.pwm == $past(req.pwm))
        else $error("request not applied");

    no_cable_a: assert property (
        r.prx_s2 == CTL_PX_NONE |-> vstate == CTL_VS_A && cap == 7'h00)
        else $error("no cable not reported as state A");

    cable_inv_a: assert property (
        r.prx_s2 != CTL_PX_NONE && !pil_ok |-> vstate == CTL_VS_INV)
        else $error("invalid state not reported");

    cable_cap_a: assert property (
        r.prx_s2 == 3'h3 |-> cap == CTL_CAP_32)
        else $error("cable capacity not reported");

    state_report_a: assert property (
        r.prx_s2 != CTL_PX_NONE && pil_ok && r.pil_s2 != CTL_VS_A
        |-> vstate == r.pil_s2)
        else $error("vehicle state not reported");

    // Status bits are sticky and an event beats a clear in the same cycle
    ist_set_a: assert property (
        |evt |=> (r.ist & $past(evt)) == $past(evt))
        else $error("event not recorded");

    ist_clear_a: assert property (
        wr && paddr == CTL_A_IST && pwdata[CTL_EV_TRIP] && !evt[CTL_EV_TRIP]
        |=> !r.ist[CTL_EV_TRIP])
        else $error("status bit not cleared");

    link_up_c: cover property (!r.conn ##1 r.conn ##[1:20] req_wr);
    trip_clear_c: cover property (
        fault ##1 !shutdown_output_n ##[1:50] $rose(shutdown_output_n));
    ferr_c: cover property (req_wr && frame_bad);
    irq_c: cover property ($rose(irq));
    tmo_drop_c: cover property (r.conn && tick && r.tmo_cnt == 16'h0000);

endmodule : ctl_trip

`default_nettype wire

// file: ctl_vehicle.sv
// Vehicle side model driving the pilot and proximity pins
`timescale 1ns/100ps
`default_nettype none
module ctl_vehicle import ctl_pkg::*; (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Wanted pin codes
    input wire logic [2:0] want_pilot,
    input wire logic [2:0] want_prox,
    // Pins toward the block
    output logic [2:0] pilot_code,
    output logic [2:0] prox_code
);
    // Pins move on an edge only; the block syncs them, so no glitch is shown
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pilot_code <= CTL_VS_A;
            prox_code <= CTL_PX_NONE;
        end else begin
            pilot_code <= want_pilot;
            prox_code <= want_prox;
        end
    end
endmodule : ctl_vehicle
`default_nettype wire

// file: ctl_trip_tb.sv
// Testbench of the charge trip latch block
`timescale 1ns/100ps
`default_nettype none
module ctl_trip_tb import ctl_pkg::*;;
    // ********************************************************
    // Signals
    // ********************************************************
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready;
    logic pslverr;
    logic er;
    logic sdn_n;
    logic irq;
    ctl_out_t pout;
    logic [2:0] pilot_code;
    logic [2:0] prox_code;
    logic [2:0] want_pilot = 3'h1;
    logic [2:0] want_prox = 3'h0;
    int miscompares = 0;
    int comparisons = 0;
    // Rows: pilot, proximity, expected response bits [10:0]
    logic [16:0] rows [8] = '{
        {CTL_VS_A, 3'h0, 7'h00, 1'b0, CTL_VS_A},
        {CTL_VS_A, 3'h3, CTL_CAP_32, 1'b0, CTL_VS_INV},
        {CTL_VS_B, 3'h3, CTL_CAP_32, 1'b0, CTL_VS_B},
        {CTL_VS_C, 3'h3, CTL_CAP_32, 1'b0, CTL_VS_C},
        {CTL_VS_D, 3'h3, CTL_CAP_32, 1'b0, CTL_VS_D},
        {CTL_VS_B, 3'h1, CTL_CAP_13, 1'b0, CTL_VS_B},
        {CTL_VS_C, 3'h2, CTL_CAP_20, 1'b0, CTL_VS_C},
        {CTL_VS_D, 3'h4, CTL_CAP_63, 1'b0, CTL_VS_D}};

    always #5 clock = ~clock;

    // Short tick and timeout keep the link timer within a few hundred cycles
    ctl_trip #(.TICK_CYCLES(100), .DEF_TMO_MS(3)) dut (.clock(clock),
        .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pilot_code(pilot_code), .prox_code(prox_code),
        .shutdown_output_n(sdn_n), .pilot_out(pout), .irq(irq));

    ctl_vehicle car (.clock(clock), .rstn(rstn), .want_pilot(want_pilot),
        .want_prox(want_prox), .pilot_code(pilot_code),
        .prox_code(prox_code));

    // ********************************************************
    // Tasks
    // ********************************************************
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
        comparisons++;
        if (seen !== ex) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, ex, seen);
        end
    endtask : chk

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) miscompares++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wt(input int n);
        repeat (n) @(posedge clock);
        @(negedge clock);
    endtask : wt

    task req(input logic p, b, c, input logic [5:0] il, input logic [7:0] bad);
        ctl_req_t q;
        q = '0;
        q.pwm = p;
        q.brk = b;
        q.clr = c;
        q.ilim = il;
        q.dout = 8'hA5;
        q.crc = q[7:0] ^ q[15:8] ^ q[23:16] ^ bad;
        apb(1'b1, CTL_A_REQ, q);
    endtask : req

    task pins(input logic [2:0] pl);
        @(posedge clock);
        want_pilot <= pl;
        wt(6);
    endtask : pins

    task close_out;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out

    // ********************************************************
    // Sequence
    // ********************************************************
    initial begin
        repeat (3) @(posedge clock);
        rstn <= 1'b1;
        wt(0);
        chk("sdn_rst", 32'(sdn_n), 32'h0);
        chk("pout_rst", 32'(pout), 32'h0);
        req(1'b1, 1'b1, 1'b0, 6'h20, 8'h00);
        wt(1);
        chk("pout_idle", 32'(pout), 32'h0);
        apb(1'b1, CTL_A_CONN, 32'h1);
        apb(1'b0, CTL_A_CONN, 32'h0);
        chk("conn", 32'(rd[0]), 32'h1);
        req(1'b0, 1'b0, 1'b1, 6'h00, 8'h00);
        wt(0);
        chk("release", 32'(sdn_n), 32'h1);
        req(1'b1, 1'b1, 1'b0, CTL_ILIM_MAX, 8'h00);
        wt(0);
        chk("pout_chg", 32'(pout), {16'h0, 2'h3, CTL_ILIM_MAX, 8'hA5});
        apb(1'b0, CTL_A_OUT, 32'h0);
        chk("out_rd", rd, {16'h0, 2'h3, CTL_ILIM_MAX, 8'hA5});
        for (int i = 0; i < 8; i++) begin
            @(posedge clock);
            want_prox <= rows[i][13:11];
            pins(rows[i][16:14]);
            apb(1'b0, CTL_A_RESP, 32'h0);
            chk("resp", 32'(rd[10:0]), 32'(rows[i][10:0]));
        end
        // Cable removed: state A is reported, then the controller idles
        @(posedge clock);
        want_prox <= CTL_PX_NONE;
        pins(CTL_VS_A);
        apb(1'b0, CTL_A_RESP, 32'h0);
        chk("unplug", 32'(rd[10:0]), 32'(CTL_VS_A));
        req(1'b0, 1'b0, 1'b0, 6'h00, 8'h00);
        wt(0);
        chk("pout_off", 32'(pout), 32'h000000A5);
        // Fault, interrupt and release order
        apb(1'b1, CTL_A_IST, 32'hF);
        apb(1'b1, CTL_A_IMSK, 32'h1);
        pins(CTL_VS_E);
        chk("trip", 32'(sdn_n), 32'h0);
        chk("irq_on", 32'(irq), 32'h1);
        apb(1'b1, CTL_A_IMSK, 32'h0);
        wt(0);
        chk("irq_mask", 32'(irq), 32'h0);
        req(1'b0, 1'b0, 1'b1, 6'h00, 8'h00);
        wt(1);
        chk("clr_fault", 32'(sdn_n), 32'h0);
        pins(CTL_VS_B);
        chk("gone", 32'(sdn_n), 32'h1);
        pins(CTL_VS_F);
        pins(CTL_VS_B);
        chk("hold", 32'(sdn_n), 32'h0);
        req(1'b0, 1'b0, 1'b1, 6'h00, 8'h00);
        wt(0);
        chk("release2", 32'(sdn_n), 32'h1);
        apb(1'b0, CTL_A_IST, 32'h0);
        chk("ist_set", 32'(rd[3:0]), 32'h1);
        apb(1'b1, CTL_A_IST, 32'h1);
        apb(1'b0, CTL_A_IST, 32'h0);
        chk("ist_w1c", 32'(rd[3:0]), 32'h0);
        // A cable fault on the proximity pin trips as well
        @(posedge clock);
        want_prox <= CTL_PX_BAD;
        wt(6);
        chk("prox_trip", 32'(sdn_n), 32'h0);
        @(posedge clock);
        want_prox <= CTL_PX_NONE;
        wt(6);
        // Timeout of 1 ms set by configuration, checksum on
        apb(1'b1, CTL_A_CFG, 32'h0001_0001);
        req(1'b1, 1'b0, 1'b0, CTL_ILIM_MIN, 8'h00);
        wt(0);
        chk("pout_crc", 32'(pout),
            {16'h0, 2'h2, CTL_ILIM_MIN, 8'hA5});
        // Well inside two ticks, whatever the phase of the tick counter
        wt(50);
        apb(1'b0, CTL_A_CONN, 32'h0);
        chk("conn_hold", 32'(rd[0]), 32'h1);
        wt(150);
        apb(1'b0, CTL_A_CONN, 32'h0);
        chk("tmo_drop", 32'(rd[0]), 32'h0);
        chk("drop_sdn", 32'(sdn_n), 32'h0);
        chk("drop_pout", 32'(pout), 32'h0);
        // Bad checksum drops the link
        apb(1'b1, CTL_A_CONN, 32'h1);
        apb(1'b1, CTL_A_IST, 32'hF);
        apb(1'b1, CTL_A_CFG, 32'h0001_0003);
        req(1'b1, 1'b0, 1'b0, CTL_ILIM_MIN, 8'hFF);
        apb(1'b0, CTL_A_CONN, 32'h0);
        chk("crc_drop", 32'(rd[0]), 32'h0);
        apb(1'b0, CTL_A_IST, 32'h0);
        chk("ist_ferr", 32'(rd[2:1]), 32'h3);
        apb(1'b0, 8'h1C, 32'h0);
        chk("unmap_err", 32'(er), 32'h1);
        chk("unmap_rd", rd, 32'h0);
        // Reset in mid-run while the link is up
        apb(1'b1, CTL_A_CONN, 32'h1);
        req(1'b0, 1'b0, 1'b1, 6'h00, 8'h00);
        wt(0);
        chk("pre_rst", 32'(sdn_n), 32'h1);
        @(posedge clock);
        rstn <= 1'b0;
        wt(1);
        chk("rst_sdn", 32'(sdn_n), 32'h0);
        chk("rst_pout", 32'(pout), 32'h0);
        @(posedge clock);
        rstn <= 1'b1;
        apb(1'b0, CTL_A_CFG, 32'h0);
        chk("rst_cfg", rd, 32'h00000003);
        apb(1'b0, CTL_A_CONN, 32'h0);
        chk("rst_conn", 32'(rd[0]), 32'h0);
        close_out();
    end

    // Run takes under 2000 cycles
    initial begin
        repeat (5000) @(posedge clock);
        miscompares++;
        close_out();
    end
endmodule : ctl_trip_tb
`default_nettype wire
